/* File: inc/bce_pkg.sv */
// bus cycle status encoder: shared types and constants
package bce_pkg;

   typedef enum logic [2:0] {
      ST_TI,
      ST_T1,
      ST_T2,
      ST_T3,
      ST_TW,
      ST_T4
   } bce_state_t;

   // three-line status codes, bit 2 first
   localparam logic [2:0] CODE_INTA    = 3'h0;
   localparam logic [2:0] CODE_IO_RD   = 3'h1;
   localparam logic [2:0] CODE_IO_WR   = 3'h2;
   localparam logic [2:0] CODE_HALT    = 3'h3;
   localparam logic [2:0] CODE_FETCH   = 3'h4;
   localparam logic [2:0] CODE_MEM_RD  = 3'h5;
   localparam logic [2:0] CODE_MEM_WR  = 3'h6;
   localparam logic [2:0] CODE_PASSIVE = 3'h7;

   // values after reset
   localparam bce_state_t RST_STATE = ST_TI;
   localparam logic       RST_GRANT = 1'b0;
   localparam logic       RST_FLOAT = 1'b1;

   typedef struct packed {
      logic cycle_status_bit2;
      logic cycle_status_bit1;
      logic cycle_status_bit0;
      logic oe;
   } bce_max_t;

   typedef struct packed {
      logic io_mem_sel;
      logic transfer_direction;
      logic min_mode_status_line;
      logic oe;
   } bce_min_t;

endpackage

/* File: core/bce_status_encoder.sv */
// bus cycle status encoder: cycle sequencer and status pin drivers
// How it works
// R01: the active code is driven in T4, T1 and T2 of a bus cycle.
// R02: the lines return to passive 111 in T3 and in every wait state.
// R03: a move away from passive in T4 marks a new cycle start.
// R04: the return to passive in T3 or a wait state marks the cycle end.
// R05: the status lines float while the bus is granted away.
// R06: in the first reset clock the lines drive high, then they float.
// R07: codes 000 interrupt ack, 001 port read, 010 port write.
// R08: in minimum mode a code fetch drives select, direction, status low.
// R09: the outside controller builds every strobe from the status lines.
// R10: three-line status is used only with the mode strap at ground.
// R11: codes 011 halt, 100 fetch, 101 mem read, 110 mem write, 111 idle.
// R12: minimum-mode status equals the lowest maximum-mode status bit.
// R13: idle clocks between cycles hold the passive code.
`timescale 1ns/1ps
module bce_status_encoder
   import bce_pkg::*;
(
   // clock, reset, enable
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       ce_in,
   // strap: low selects maximum mode
   input  wire logic       mode_strap_in,
   // cycle request from the execution side
   input  wire logic       cyc_req_in,
   input  wire logic [2:0] cyc_code_in,
   input  wire logic       ready_in,
   // bus hold handshake
   input  wire logic       hold_req_in,
   output logic            bus_grant_ack_out,
   // pins
   output bce_max_t        max_pins_out,
   output bce_min_t        min_pins_out,
   output logic            cyc_taken_out
);

   bce_state_t state;
   bce_state_t next_state;
   logic [2:0] code;
   logic [2:0] next_code;
   logic       pend;
   logic       next_pend;
   logic       grant;
   logic       next_grant;
   logic       float_q;
   logic       next_float;
   logic       in_rst;
   logic       next_in_rst;
   logic       next_taken;
   logic       take;
   logic       active;
   logic [2:0] shown;
   bce_max_t   max_q;
   bce_max_t   next_max;
   bce_min_t   min_q;
   bce_min_t   next_min;

   // hold wins over a new request at a cycle boundary
   always_comb begin
      take = cyc_req_in && !hold_req_in &&
             ((state == ST_TI && !grant) ||
              ((state == ST_T3 || state == ST_TW) && ready_in));
   end

   always_comb begin
      next_state  = state;
      next_code   = code;
      next_pend   = pend;
      next_grant  = grant;
      next_float  = float_q;
      next_in_rst = 1'b0;
      next_taken  = take;
      case (state)
         ST_TI: begin
            if (grant) begin
               next_grant = hold_req_in;
            end else if (hold_req_in) begin
               next_grant = 1'b1; // R05
            end else if (take) begin
               next_state = ST_T4; // R03
               next_pend  = 1'b1;
               next_code  = cyc_code_in;
               next_float = 1'b0;
            end
         end
         ST_T1: next_state = ST_T2;
         ST_T2: next_state = ST_T3;
         ST_T3, ST_TW: begin
            if (ready_in) begin
               next_state = ST_T4;
               next_pend  = take;
               if (take) begin
                  next_code = cyc_code_in;
               end
            end else begin
               next_state = ST_TW;
            end
         end
         ST_T4: begin
            next_state = pend ? ST_T1 : ST_TI;
            next_pend  = 1'b0;
            if (!pend && hold_req_in) begin
               next_grant = 1'b1; // R05
            end
         end
         default: next_state = ST_TI;
      endcase
      if (!rst_n_in) begin
         next_state  = RST_STATE;
         next_code   = CODE_PASSIVE;
         next_pend   = 1'b0;
         next_grant  = RST_GRANT;
         next_float  = RST_FLOAT;
         next_in_rst = 1'b1;
         next_taken  = 1'b0;
      end
   end

   // pins follow the state being entered, so they change with it
   always_comb begin
      active = (next_state == ST_T4 && next_pend) || // R01 R03
               next_state == ST_T1 || next_state == ST_T2;
      shown  = active ? next_code : CODE_PASSIVE; // R02 R04 R13
      next_max.cycle_status_bit2 = shown[2]; // R07 R11
      next_max.cycle_status_bit1 = shown[1];
      next_max.cycle_status_bit0 = shown[0];
      next_max.oe = !mode_strap_in && !next_grant && !next_float; // R05 R10
      next_min.io_mem_sel           = !shown[2]; // R08
      next_min.transfer_direction   = shown[1];
      next_min.min_mode_status_line = shown[0]; // R12
      next_min.oe = mode_strap_in && !next_grant && !next_float;
      if (!rst_n_in) begin
         // high in the first reset clock only, floating afterwards
         next_max.oe = !in_rst && !mode_strap_in; // R06
         next_min.oe = 1'b0;
      end
   end

   // reset overrides the clock enable
   always_ff @(posedge ref_clk_in) begin
      if (ce_in || !rst_n_in) begin
         state   <= next_state;
         code    <= next_code;
         pend    <= next_pend;
         grant   <= next_grant;
         float_q <= next_float;
         in_rst  <= next_in_rst;
         max_q   <= next_max;
         min_q   <= next_min;
         cyc_taken_out <= next_taken;
      end
   end

   assign max_pins_out      = max_q;
   assign min_pins_out      = min_q;
   assign bus_grant_ack_out = grant;

   // checks
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   logic [2:0] pin_code;
   assign pin_code = {max_q.cycle_status_bit2, max_q.cycle_status_bit1,
                      max_q.cycle_status_bit0};

   sequence s_announce;
      state == ST_T4 && pin_code != CODE_PASSIVE;
   endsequence
   sequence s_body;
      state == ST_T1 && pin_code == code ##1
      state == ST_T2 && pin_code == code;
   endsequence
   sequence s_close;
      state == ST_T3 && pin_code == CODE_PASSIVE;
   endsequence

   cycle_start_a: assert property ( // R03
      s_announce ##0 ce_in ##1 ce_in |-> s_body)
      else $error("cycle start not followed by T1 and T2");
   active_body_a: assert property ( // R01
      (state == ST_T1 || state == ST_T2) |-> pin_code != CODE_PASSIVE)
      else $error("status passive in T1 or T2");
   cycle_end_a: assert property ( // R04
      state == ST_T2 && ce_in |=> s_close)
      else $error("status not passive in T3");
   wait_passive_a: assert property ( // R02
      (state == ST_T3 || state == ST_TW) |-> pin_code == CODE_PASSIVE)
      else $error("status active in T3 or wait");
   idle_passive_a: assert property ( // R13
      state == ST_TI |-> pin_code == CODE_PASSIVE)
      else $error("status active while idle");
   hold_float_a: assert property ( // R05
      grant |-> !max_q.oe && !min_q.oe)
      else $error("status driven while bus granted");
   code_taken_a: assert property ( // R07
      take && ce_in |=> pin_code == $past(cyc_code_in) && state == ST_T4)
      else $error("announced code differs from request");
   min_map_a: assert property ( // R08
      min_q.oe |-> min_q.min_mode_status_line == pin_code[0] &&
                   min_q.io_mem_sel == !pin_code[2] &&
                   min_q.transfer_direction == pin_code[1])
      else $error("minimum-mode lines disagree with code");
   min_code_a: assert property ( // R08 R12
      min_q.oe && (state == ST_T1 || state == ST_T2) |->
         {!min_q.io_mem_sel, min_q.transfer_direction,
          min_q.min_mode_status_line} == code)
      else $error("minimum-mode lines disagree with cycle code");
   strap_mode_a: assert property ( // R10
      mode_strap_in && ce_in |=> !max_q.oe)
      else $error("status lines driven in minimum mode");
   reset_high_a: assert property (disable iff (1'b0) // R06
      !rst_n_in && !in_rst && !mode_strap_in |=>
         max_q.oe && pin_code == CODE_PASSIVE ##1
         (rst_n_in || !max_q.oe))
      else $error("reset drive sequence wrong");

endmodule

/* File: dv/bce_ctrl_model.sv */
// bus controller model: decodes the status lines into one command
`timescale 1ns/1ps
module bce_ctrl_model
   import bce_pkg::*;
(
   // clock and status pins
   input  wire logic     ref_clk_in,
   input  wire bce_max_t pins_in,
   // decoded command
   output logic          cmd_on_out,
   output logic [2:0]    cmd_out
);
   logic [2:0] stat;
   // floating lines read as passive
   assign stat = pins_in.oe ? pins_in[3:1] : CODE_PASSIVE;
   initial cmd_on_out = 1'b0;
   initial cmd_out = CODE_PASSIVE;
   always @(posedge ref_clk_in) begin
      if (stat != CODE_PASSIVE && !cmd_on_out) begin
         cmd_on_out <= 1'b1;
         cmd_out    <= stat;
      end else if (stat == CODE_PASSIVE) begin
         cmd_on_out <= 1'b0;
      end
   end
endmodule

/* File: dv/tb.sv */
// self-checking testbench for the bus cycle status encoder
`timescale 1ns/1ps
module tb;
   import bce_pkg::*;
   logic       ref_clk_in, rst_n_in, ce_in, mode_strap_in, cyc_req_in;
   logic       ready_in, hold_req_in, bus_grant_ack_out, cyc_taken_out;
   logic       cmd_on;
   logic [2:0] cyc_code_in, cmd;
   bce_max_t   max_pins_out;
   bce_min_t   min_pins_out;
   int         fail_count, check_count, cycles;
   bce_status_encoder u_bce_status_encoder (.ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in), .ce_in(ce_in), .mode_strap_in(mode_strap_in),
      .cyc_req_in(cyc_req_in), .cyc_code_in(cyc_code_in),
      .ready_in(ready_in), .hold_req_in(hold_req_in),
      .bus_grant_ack_out(bus_grant_ack_out), .max_pins_out(max_pins_out),
      .min_pins_out(min_pins_out), .cyc_taken_out(cyc_taken_out));
   bce_ctrl_model u_bce_ctrl_model (.ref_clk_in(ref_clk_in),
      .pins_in(max_pins_out), .cmd_on_out(cmd_on), .cmd_out(cmd));
   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end
   task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick;
      @(posedge ref_clk_in);
      #1;
   endtask
   task end_of_test;
      if (fail_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         end_of_test;
      end
   end
   // one bus cycle with w wait states, checked in either mode
   task automatic run_cycle(input logic [2:0] c, input logic mn, input int w);
      int n;
      logic [3:0] pas;
      pas = mn ? 4'h7 : 4'hf;
      ready_in = (w == 0);
      cyc_req_in = 1'b1;
      cyc_code_in = c;
      n = 0;
      do begin
         tick;
         n++;
      end while (cyc_taken_out !== 1'b1 && n < 20);
      cyc_req_in = 1'b0;
      cmp({3'h0, mn ? max_pins_out.oe : min_pins_out.oe}, 4'h0);
      repeat (3) begin
         if (mn) cmp(min_pins_out, {~c[2], c[1:0], 1'b1});
         else cmp(max_pins_out, {c, 1'b1});
         tick;
      end
      cmp(mn ? min_pins_out : max_pins_out, pas);
      if (!mn) cmp({cmd_on, cmd}, {1'b1, c});
      repeat (w) begin
         tick;
         cmp(mn ? min_pins_out : max_pins_out, pas);
      end
      ready_in = 1'b1;
      tick;
      if (!mn) cmp({cmd_on, cmd}, {1'b0, c});
      tick;
      cmp(mn ? min_pins_out : max_pins_out, pas);
   endtask
   // bus granted away while a cycle is wanted
   task automatic hold_test;
      hold_req_in = 1'b1;
      cyc_req_in = 1'b1;
      cyc_code_in = CODE_MEM_RD;
      tick;
      tick;
      cmp({bus_grant_ack_out, cyc_taken_out, max_pins_out.oe, 1'b0}, 4'h8);
      hold_req_in = 1'b0;
      cyc_req_in = 1'b0;
      tick;
   endtask
   // mid-run reset: high for one clock, then floating
   task automatic reset_test;
      rst_n_in = 1'b0;
      tick;
      cmp(max_pins_out, 4'hf);
      cmp(min_pins_out, 4'h6);
      tick;
      cmp(max_pins_out, 4'he);
      rst_n_in = 1'b1;
      tick;
      cmp(max_pins_out, 4'he);
   endtask
   initial begin
      rst_n_in = 1'b0;
      ce_in = 1'b1;
      mode_strap_in = 1'b0;
      cyc_req_in = 1'b0;
      cyc_code_in = 3'h0;
      ready_in = 1'b1;
      hold_req_in = 1'b0;
      tick;
      // no earlier clock at power-up, so only the code is known here
      cmp({max_pins_out[3:1], 1'b1}, 4'hf);
      tick;
      cmp(max_pins_out, 4'he);
      repeat (4) tick;
      rst_n_in = 1'b1;
      tick;
      cmp(max_pins_out, 4'he);
      for (int i = 0; i < 7; i++) run_cycle(3'(i), 1'b0, 0);
      run_cycle(CODE_MEM_WR, 1'b0, 2);
      hold_test;
      reset_test;
      mode_strap_in = 1'b1;
      run_cycle(CODE_FETCH, 1'b1, 0);
      run_cycle(CODE_IO_RD, 1'b1, 1);
      end_of_test;
   end
endmodule
